/* File: src/dasc_pkg.sv */
// Purpose: Constants and types for the DDS accumulator and sweep control block
// Assumes: Serial port pins sampled on sys_clk; MSB-first transfers only
// Notes on behaviour
// - Profile slots six and seven at 0x0c/0x0d; tuning word 47:0, phase offset above.
// - Both profile slots reset to all zeros.
// - In auto or hardware sync mode the lock pin is an input.
// - Lock error flag bit 24 sets on loss of lock and stays set.
// - Reading the control register clears the lock error flag.
// - Ramp-rate down counter on sys_clk, loaded at every sweep step.
// - Bit 23 lets an update strobe reload the ramp counter mid-sweep.
// - Bit 22: update strobe clears frequency accumulator and restarts the sweep.
// - Bit 21: update strobe clears phase accumulator for one cycle.
// - Bit 20 selects sine when one, cosine when zero.
// - Bit 19 clears and holds the frequency accumulator at zero.
// - Bit 18 clears and holds the phase accumulator at zero.
// - Bit 17 enables linear sweep; otherwise a single fixed tone.
// - Bit 16 clear: dwell at the end word when reached.
// - Bit 16 set: return to start word, wait for select pin rise.
package dasc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [4:0] ADDR_MAIN_CONTROL = 5'h00;
	localparam logic [4:0] ADDR_PROFILE_SIX = 5'h0c;
	localparam logic [4:0] ADDR_PROFILE_SEVEN = 5'h0d;
	localparam logic [6:0] WIDTH_PROFILE = 7'h40;
	localparam logic [6:0] WIDTH_CONTROL = 7'h20;
	localparam logic [6:0] WIDTH_INSTR = 7'h08;
	localparam logic [6:0] WIDTH_UNMAPPED = 7'h08;
	localparam int INSTR_READ_BIT = 7;
	localparam logic [63:0] PROFILE_RESET = 64'h0;
	localparam logic [31:0] CONTROL_RESET = 32'h0;
	localparam logic [31:0] CONTROL_WRITE_MASK = 32'h00ff_000a;
	// ----------------------------------------
	// Control bit positions and fields
	// ----------------------------------------
	localparam int BIT_LOCK_ERR = 24;
	localparam int BIT_LOAD_RATE = 23;
	localparam int BIT_AUTO_CLR_FREQ = 22;
	localparam int BIT_AUTO_CLR_PHASE = 21;
	localparam int BIT_SINE = 20;
	localparam int BIT_FREQ_HOLD = 19;
	localparam int BIT_PHASE_HOLD = 18;
	localparam int BIT_SWEEP_EN = 17;
	localparam int BIT_NO_DWELL = 16;
	localparam int BIT_AUTO_SYNC = 3;
	localparam int BIT_HW_SYNC = 1;
	localparam int TUNE_W = 48;
	localparam int PHASE_W = 14;
	localparam int PHASE_LSB = 48;
	localparam int RATE_W = 16;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		DASC_SP_INSTR = 4'b0001,
		DASC_SP_WRITE = 4'b0010,
		DASC_SP_READ = 4'b0100,
		DASC_SP_DONE = 4'b1000
	} dasc_sp_t;
	typedef enum logic [2:0] {
		DASC_SW_RUN = 3'b001,
		DASC_SW_DWELL = 3'b010,
		DASC_SW_HOME = 3'b100
	} dasc_sw_t;
endpackage

/* File: src/dasc_ramp_if.sv */
// Purpose: Link between sweep control and the ramp-rate down counter
// Assumes: Single sys_clk domain
// Notes: step is a one-cycle pulse from the counter
`timescale 1ns/100ps
interface dasc_ramp_if;
	logic load;
	logic run;
	logic [15:0] rate;
	logic step;
	modport ctl (output load, output run, output rate, input step);
	modport cnt (input load, input run, input rate, output step);
endinterface

/* File: src/dasc_ramp_counter.sv */
// Purpose: Ramp-rate down counter timing each sweep step
// Assumes: rate stable while running
// Notes: reloads itself on expiry, or on load
`timescale 1ns/100ps
module dasc_ramp_counter
	import dasc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	dasc_ramp_if.cnt ramp
);
	typedef struct packed {
		logic [RATE_W-1:0] cnt;
		logic step;
	} dasc_rc_t;
	dasc_rc_t s;
	dasc_rc_t next_s;

	// Countdown and reload at each new step
	always_comb begin
		next_s = s;
		next_s.step = 1'b0;
		if (ramp.load) begin
			next_s.cnt = ramp.rate;
		end else if (ramp.run) begin
			if (s.cnt == '0) begin
				next_s.step = 1'b1;
				next_s.cnt = ramp.rate;
			end else begin
				next_s.cnt = s.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ramp.step = s.step;

	property p_rc_load;
		@(posedge sys_clk) disable iff (!rst_b) ramp.load |=> s.cnt == $past(ramp.rate) && !s.step;
	endproperty
	a_rc_load: assert property (p_rc_load) else $error("ramp counter not loaded");

	property p_rc_expire;
		@(posedge sys_clk) disable iff (!rst_b) ramp.run && !ramp.load && s.cnt == '0 |=> s.step;
	endproperty
	a_rc_expire: assert property (p_rc_expire) else $error("ramp counter expiry missed");
endmodule

/* File: src/dasc_strobe_sync.sv */
// Purpose: Two-flop synchroniser with rising-edge pulse
// Assumes: Strobe high for at least two sys_clk cycles
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
module dasc_strobe_sync (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic strobe_in,
	output logic pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic pulse;
	} dasc_ss_t;
	dasc_ss_t s;
	dasc_ss_t next_s;

	// Shift chain and edge detect on the settled stages only
	always_comb begin
		next_s = s;
		next_s.s1 = strobe_in;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		next_s.pulse = s.s2 & ~s.s3;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pulse = s.pulse;

	property p_ss_single;
		@(posedge sys_clk) disable iff (!rst_b) pulse |=> !pulse;
	endproperty
	a_ss_single: assert property (p_ss_single) else $error("update pulse longer than one cycle");
endmodule

/* File: src/dasc_core.sv */
// Purpose: Serial register file, accumulators and linear sweep control
// Assumes: Serial pins synchronous to sys_clk, sclk well below sys_clk/2
// Notes: Sweep start/end words are the tuning words of slots six and seven
`timescale 1ns/100ps
module dasc_core
	import dasc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic sclk,
	input wire logic sdio_in,
	output logic sdo,
	output logic sdo_oe,
	input wire logic io_update,
	input wire logic profile_select_zero,
	input wire logic pll_locked,
	input wire logic lock_sync_in,
	output logic lock_sync_out,
	output logic lock_sync_oe,
	output logic sync_advance,
	input wire logic [47:0] delta_word,
	input wire logic [15:0] ramp_rate_value,
	output logic [47:0] tuning_word,
	output logic [13:0] phase_word,
	output logic sine_select
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic sclk_q;
		dasc_sp_t sp;
		logic [6:0] bit_cnt;
		logic [6:0] width;
		logic [4:0] addr;
		logic [63:0] shift;
		logic [63:0] profile_slot_six;
		logic [63:0] profile_slot_seven;
		logic [31:0] main_control;
		logic lock_err;
		logic sdo;
		logic sdo_oe;
		logic lock_sync_out;
		logic lock_sync_oe;
		logic sync_q;
		logic sync_advance;
		dasc_sw_t sw;
		logic ps0_q;
		logic [TUNE_W-1:0] freq_acc;
		logic [TUNE_W-1:0] phase_acc;
		logic [TUNE_W-1:0] tuning_word;
		logic [PHASE_W-1:0] phase_word;
		logic sine_select;
	} dasc_st_t;
	dasc_st_t s;
	dasc_st_t next_s;
	logic upd_pulse;
	logic rd_clear;
	logic sweeping;
	dasc_ramp_if ramp ();

	// ----------------------------------------
	// Register decode helpers
	// ----------------------------------------
	function automatic logic [6:0] reg_width(input logic [4:0] a);
		case (a)
			ADDR_PROFILE_SIX: reg_width = WIDTH_PROFILE;
			ADDR_PROFILE_SEVEN: reg_width = WIDTH_PROFILE;
			ADDR_MAIN_CONTROL: reg_width = WIDTH_CONTROL;
			default: reg_width = WIDTH_UNMAPPED;
		endcase
	endfunction

	// Readback value, left aligned so the MSB leaves first
	function automatic logic [63:0] read_value(input logic [4:0] a, input dasc_st_t st);
		logic [63:0] v;
		v = '0;
		case (a)
			ADDR_PROFILE_SIX: v = st.profile_slot_six;
			ADDR_PROFILE_SEVEN: v = st.profile_slot_seven;
			ADDR_MAIN_CONTROL: begin
				v[31:0] = st.main_control & CONTROL_WRITE_MASK;
				v[BIT_LOCK_ERR] = st.lock_err;
			end
			default: v = '0;
		endcase
		read_value = v << (WIDTH_PROFILE - reg_width(a));
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	dasc_strobe_sync u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.strobe_in(io_update),
		.pulse(upd_pulse)
	);

	dasc_ramp_counter u_ramp (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.ramp(ramp)
	);

	// Counter runs only while actively stepping
	assign sweeping = s.main_control[BIT_SWEEP_EN] && s.sw == DASC_SW_RUN && !s.main_control[BIT_FREQ_HOLD];
	assign ramp.run = sweeping;
	assign ramp.rate = ramp_rate_value;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic sclk_rise;
		logic sclk_fall;
		logic [63:0] n;
		logic [TUNE_W-1:0] start_w;
		logic [TUNE_W-1:0] span;
		logic [TUNE_W:0] sum;
		logic restart;
		logic [PHASE_W-1:0] offset;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		n = '0;
		start_w = '0;
		span = '0;
		sum = '0;
		restart = 1'b0;
		offset = '0;
		next_s = s;
		rd_clear = 1'b0;
		ramp.load = 1'b0;
		sclk_rise = sclk && !s.sclk_q;
		sclk_fall = !sclk && s.sclk_q;
		next_s.sclk_q = sclk;
		n = {s.shift[62:0], sdio_in};

		// Serial port: instruction byte, then register bits MSB first
		if (cs_b) begin
			next_s.sp = DASC_SP_INSTR;
			next_s.bit_cnt = '0;
			next_s.sdo_oe = 1'b0;
		end else if (sclk_rise) begin
			case (s.sp)
				DASC_SP_INSTR: begin
					next_s.shift = n;
					next_s.bit_cnt = s.bit_cnt + 1'b1;
					if (s.bit_cnt + 1'b1 == WIDTH_INSTR) begin
						next_s.addr = n[4:0];
						next_s.width = reg_width(n[4:0]);
						next_s.bit_cnt = '0;
						if (n[INSTR_READ_BIT]) begin
							next_s.sp = DASC_SP_READ;
							next_s.shift = read_value(n[4:0], s);
							rd_clear = n[4:0] == ADDR_MAIN_CONTROL;
						end else begin
							next_s.sp = DASC_SP_WRITE;
						end
					end
				end
				DASC_SP_WRITE: begin
					next_s.shift = n;
					next_s.bit_cnt = s.bit_cnt + 1'b1;
					// Commit only once the full register width has arrived
					if (s.bit_cnt + 1'b1 == s.width) begin
						next_s.sp = DASC_SP_DONE;
						case (s.addr)
							ADDR_PROFILE_SIX: next_s.profile_slot_six = n;
							ADDR_PROFILE_SEVEN: next_s.profile_slot_seven = n;
							ADDR_MAIN_CONTROL: next_s.main_control = n[31:0] & CONTROL_WRITE_MASK;
							default: next_s.shift = n;
						endcase
					end
				end
				DASC_SP_READ: next_s.shift = s.shift;
				DASC_SP_DONE: next_s.shift = s.shift;
				default: next_s.sp = DASC_SP_INSTR;
			endcase
		end else if (sclk_fall && s.sp == DASC_SP_READ) begin
			next_s.sdo = s.shift[63];
			next_s.shift = {s.shift[62:0], 1'b0};
			next_s.sdo_oe = 1'b1;
		end

		// Sticky lock error; a loss in the readback cycle still sets it
		next_s.lock_err = !pll_locked || (s.lock_err && !rd_clear);

		// Shared lock/sync pin direction
		if (s.main_control[BIT_AUTO_SYNC] || s.main_control[BIT_HW_SYNC]) begin
			next_s.lock_sync_oe = 1'b0;
		end else begin
			next_s.lock_sync_oe = 1'b1;
		end
		next_s.lock_sync_out = pll_locked;
		next_s.sync_q = lock_sync_in;
		next_s.sync_advance = s.main_control[BIT_HW_SYNC] && lock_sync_in && !s.sync_q;

		// Linear sweep between the two profile tuning words
		start_w = s.profile_slot_six[TUNE_W-1:0];
		span = s.profile_slot_seven[TUNE_W-1:0] - start_w;
		sum = {1'b0, s.freq_acc} + {1'b0, delta_word};
		next_s.ps0_q = profile_select_zero;
		restart = (profile_select_zero && !s.ps0_q) ||
			(upd_pulse && s.main_control[BIT_AUTO_CLR_FREQ]);
		case (s.sw)
			DASC_SW_RUN: begin
				if (ramp.step && sweeping) begin
					if (sum >= {1'b0, span}) begin
						if (s.main_control[BIT_NO_DWELL]) begin
							next_s.freq_acc = span;
							next_s.sw = DASC_SW_HOME;
						end else begin
							next_s.freq_acc = span;
							next_s.sw = DASC_SW_DWELL;
						end
					end else begin
						next_s.freq_acc = sum[TUNE_W-1:0];
					end
				end
			end
			DASC_SW_DWELL: next_s.freq_acc = s.freq_acc;
			DASC_SW_HOME: next_s.freq_acc = '0;
			default: next_s.sw = DASC_SW_RUN;
		endcase
		if (restart) begin
			next_s.freq_acc = '0;
			next_s.sw = DASC_SW_RUN;
			ramp.load = s.main_control[BIT_SWEEP_EN];
		end
		if (upd_pulse && s.main_control[BIT_LOAD_RATE] && sweeping) begin
			ramp.load = 1'b1;
		end
		if (s.main_control[BIT_FREQ_HOLD]) begin
			next_s.freq_acc = '0;
		end

		// Tone selection: fixed profile word or swept word
		if (s.main_control[BIT_SWEEP_EN]) begin
			next_s.tuning_word = start_w + s.freq_acc;
		end else if (s.ps0_q) begin
			next_s.tuning_word = s.profile_slot_seven[TUNE_W-1:0];
		end else begin
			next_s.tuning_word = s.profile_slot_six[TUNE_W-1:0];
		end

		// Phase accumulator with hold and auto-clear
		if (s.main_control[BIT_PHASE_HOLD]) begin
			next_s.phase_acc = '0;
		end else if (upd_pulse && s.main_control[BIT_AUTO_CLR_PHASE]) begin
			next_s.phase_acc = '0;
		end else begin
			next_s.phase_acc = s.phase_acc + s.tuning_word;
		end
		offset = s.ps0_q ? s.profile_slot_seven[PHASE_LSB +: PHASE_W] : s.profile_slot_six[PHASE_LSB +: PHASE_W];
		next_s.phase_word = s.phase_acc[TUNE_W-1 -: PHASE_W] + offset;
		next_s.sine_select = s.main_control[BIT_SINE];
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s <= '0;
			s.sp <= DASC_SP_INSTR;
			s.sw <= DASC_SW_RUN;
			s.sclk_q <= 1'b0;
			s.profile_slot_six <= PROFILE_RESET;
			s.profile_slot_seven <= PROFILE_RESET;
			s.main_control <= CONTROL_RESET;
			s.lock_sync_oe <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign sdo = s.sdo;
	assign sdo_oe = s.sdo_oe;
	assign lock_sync_out = s.lock_sync_out;
	assign lock_sync_oe = s.lock_sync_oe;
	assign sync_advance = s.sync_advance;
	assign tuning_word = s.tuning_word;
	assign phase_word = s.phase_word;
	assign sine_select = s.sine_select;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_reset_zero;
		@(posedge sys_clk) !rst_b |=> s.profile_slot_six == '0 && s.profile_slot_seven == '0;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("profile slot not zero after reset");

	property p_lock_set;
		@(posedge sys_clk) disable iff (!rst_b) !pll_locked |=> s.lock_err;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock error not set");

	property p_lock_sticky;
		@(posedge sys_clk) disable iff (!rst_b) s.lock_err && !rd_clear |=> s.lock_err;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock error dropped without readback");

	property p_lock_clear;
		@(posedge sys_clk) disable iff (!rst_b) rd_clear && pll_locked |=> !s.lock_err;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("readback did not clear lock error");

	property p_pin_input;
		@(posedge sys_clk) disable iff (!rst_b)
			s.main_control[BIT_AUTO_SYNC] || s.main_control[BIT_HW_SYNC] |=> !lock_sync_oe;
	endproperty
	a_pin_input: assert property (p_pin_input) else $error("lock pin driven in sync mode");

	property p_freq_hold;
		@(posedge sys_clk) disable iff (!rst_b) s.main_control[BIT_FREQ_HOLD] |=> s.freq_acc == '0;
	endproperty
	a_freq_hold: assert property (p_freq_hold) else $error("frequency accumulator not held");

	property p_phase_hold;
		@(posedge sys_clk) disable iff (!rst_b) s.main_control[BIT_PHASE_HOLD] |=> s.phase_acc == '0;
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("phase accumulator not held");

	property p_auto_freq;
		@(posedge sys_clk) disable iff (!rst_b) upd_pulse && s.main_control[BIT_AUTO_CLR_FREQ] |=> s.freq_acc == '0;
	endproperty
	a_auto_freq: assert property (p_auto_freq) else $error("auto-clear of frequency accumulator missed");

	property p_auto_phase;
		@(posedge sys_clk) disable iff (!rst_b) upd_pulse && s.main_control[BIT_AUTO_CLR_PHASE] |=> s.phase_acc == '0;
	endproperty
	a_auto_phase: assert property (p_auto_phase) else $error("auto-clear of phase accumulator missed");

	property p_sine;
		@(posedge sys_clk) disable iff (!rst_b) ##1 sine_select == $past(s.main_control[BIT_SINE]);
	endproperty
	a_sine: assert property (p_sine) else $error("sine select does not follow control");

	property p_rate_reload;
		@(posedge sys_clk) disable iff (!rst_b) upd_pulse && s.main_control[BIT_LOAD_RATE] && sweeping |-> ramp.load;
	endproperty
	a_rate_reload: assert property (p_rate_reload) else $error("ramp reload on update missed");

	property p_home;
		@(posedge sys_clk) disable iff (!rst_b) s.sw == DASC_SW_HOME |=> s.freq_acc == '0;
	endproperty
	a_home: assert property (p_home) else $error("no-dwell return not held at start");
endmodule

/* File: verif/dasc_host_model.sv */
// Purpose: Host processor model driving the serial register port
// Assumes: Pins change at falling sys_clk edges only
// Notes: Each sclk half lasts 3 sys_clk cycles, two more than the minimum
`timescale 1ns/100ps
module dasc_host_model (
	input wire logic sys_clk,
	output logic cs_b,
	output logic sclk,
	output logic sdio_in,
	input wire logic sdo
);
	// ----------------------------------------
	// Idle pins
	// ----------------------------------------
	// Deselected with the serial clock parked low
	initial begin
		cs_b = 1'b1;
		sclk = 1'b0;
		sdio_in = 1'b0;
	end
	// ----------------------------------------
	// Frames
	// ----------------------------------------
	// Instruction then nbits data bits MSB first; stop below nbits cuts the frame short
	task automatic xfer(input logic [7:0] instr, input logic [63:0] wdata, input int nbits, input int stop,
		output logic [63:0] rdata);
		logic [71:0] sh;
		sh = {instr, wdata << (64 - nbits)};
		rdata = '0;
		@(negedge sys_clk) cs_b <= 1'b0;
		for (int i = 0; i < 8 + stop; i++) begin
			@(negedge sys_clk);
			sclk <= 1'b0;
			sdio_in <= sh[71 - i];
			repeat (3) @(negedge sys_clk);
			if (i >= 8) begin
				rdata = {rdata[62:0], sdo};
			end
			sclk <= 1'b1;
			repeat (2) @(negedge sys_clk);
		end
		@(negedge sys_clk) sclk <= 1'b0;
		repeat (3) @(negedge sys_clk);
		// Released data line flips so a stale level is never mistaken for data
		cs_b <= 1'b1;
		sdio_in <= ~sdio_in;
		repeat (3) @(negedge sys_clk);
	endtask
	// Whole-register write, every byte sent in one frame
	task automatic wr(input logic [4:0] a, input logic [63:0] d, input int n);
		logic [63:0] dummy;
		xfer({3'b000, a}, d, n, n, dummy);
	endtask
	// Whole-register read
	task automatic rd(input logic [4:0] a, input int n, output logic [63:0] r);
		xfer({3'b100, a}, 64'h0, n, n, r);
	endtask
endmodule

/* File: verif/tb_dds_accumulator_sweep_control.sv */
// Purpose: Self-checking bench for the accumulator and sweep control block
// Assumes: Inputs driven at falling sys_clk edges; 250 MHz clock
// Notes: Sweep timing is checked by value, not by exact step cycle
`timescale 1ns/100ps
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, (act), (exp)); end end
module tb_dds_accumulator_sweep_control
	import dasc_pkg::*;
;
	logic sys_clk, rst_b, cs_b, sclk, sdio_in, sdo, sdo_oe, io_update, profile_select_zero, pll_locked;
	logic lock_sync_out, lock_sync_oe, sync_advance, sine_select, sync_drive;
	logic [47:0] delta_word, tuning_word, sw, dw, ew;
	logic [15:0] ramp_rate_value;
	logic [13:0] phase_word;
	logic [63:0] r, s6, s7;
	logic [31:0] cw;
	int seed, fail_count, checked, adv_count;
	bit found;
	// Two-way lock pin: device drives while enabled, bench otherwise
	wire lock_pin = lock_sync_oe ? lock_sync_out : sync_drive;
	// Released read line shows the inverse, so a read with the driver off cannot pass
	wire sdo_pin = sdo_oe ? sdo : ~sdo;
	// ----------------------------------------
	// Design and host
	// ----------------------------------------
	dasc_core u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .sdio_in(sdio_in), .sdo(sdo),
		.sdo_oe(sdo_oe), .io_update(io_update), .profile_select_zero(profile_select_zero),
		.pll_locked(pll_locked), .lock_sync_in(lock_pin), .lock_sync_out(lock_sync_out),
		.lock_sync_oe(lock_sync_oe), .sync_advance(sync_advance), .delta_word(delta_word),
		.ramp_rate_value(ramp_rate_value), .tuning_word(tuning_word), .phase_word(phase_word),
		.sine_select(sine_select));
	dasc_host_model u_host (.sys_clk(sys_clk), .cs_b(cs_b), .sclk(sclk), .sdio_in(sdio_in), .sdo(sdo_pin));
	// Clock
	initial sys_clk = 1'b0;
	always #2 sys_clk = ~sys_clk;
	// Count advance pulses seen by the design
	always @(posedge sys_clk) begin
		if (sync_advance === 1'b1) adv_count++;
	end
	// ----------------------------------------
	// Expectations and helpers
	// ----------------------------------------
	// Readable control bits only; the lock flag is never writable
	function automatic logic [31:0] exp_ctrl(input logic [31:0] w);
		return w & CONTROL_WRITE_MASK;
	endfunction
	// A sweep may only show the start word plus whole steps
	function automatic logic on_grid(input logic [47:0] t);
		return (t === sw) || (t === sw + dw) || (t === sw + 2 * dw) || (t === ew);
	endfunction
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic pulse_update();
		@(negedge sys_clk) io_update <= 1'b1;
		repeat (3) @(negedge sys_clk);
		io_update <= 1'b0;
	endtask
	// New sweep: select pin low, then high
	task automatic restart();
		@(negedge sys_clk) profile_select_zero <= 1'b0;
		repeat (3) @(negedge sys_clk);
		profile_select_zero <= 1'b1;
		repeat (3) @(negedge sys_clk);
	endtask
	// Bounded wait for a tuning word, checking every step on the way
	task automatic wait_word(input logic [47:0] v, input int bound);
		int n;
		n = 0;
		while (tuning_word !== v && n < bound) begin
			@(negedge sys_clk);
			`CHK(on_grid(tuning_word), 1'b1)
			n++;
		end
		if (n >= bound) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, tuning_word, v);
			print_verdict();
		end
	endtask
	task automatic hold_word(input logic [47:0] v, input int n);
		repeat (n) begin
			@(negedge sys_clk);
			`CHK(tuning_word, v)
		end
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 35440;
		{rst_b, io_update, profile_select_zero, sync_drive} = 4'h0;
		pll_locked = 1'b1;
		delta_word = 48'h0;
		ramp_rate_value = 16'h0;
		fail_count = 0;
		checked = 0;
		adv_count = 0;
		repeat (6) @(negedge sys_clk);
		rst_b <= 1'b1;
		@(negedge sys_clk);
		// Reset values
		u_host.rd(ADDR_PROFILE_SIX, 64, r);
		`CHK(r, PROFILE_RESET)
		`CHK(sdo_oe, 1'b0)
		u_host.rd(ADDR_PROFILE_SEVEN, 64, r);
		`CHK(r, PROFILE_RESET)
		`CHK({tuning_word, phase_word, sine_select}, 63'h0)
		// Random slot contents, open bits kept zero
		for (int k = 0; k < 3; k++) begin
			s6 = {$random(seed), $random(seed)} & 64'h3fff_ffff_ffff_ffff;
			s7 = {$random(seed), $random(seed)} & 64'h3fff_ffff_ffff_ffff;
			u_host.wr(ADDR_PROFILE_SIX, s6, 64);
			u_host.wr(ADDR_PROFILE_SEVEN, s7, 64);
			u_host.rd(ADDR_PROFILE_SIX, 64, r);
			`CHK(r, s6)
			u_host.rd(ADDR_PROFILE_SEVEN, 64, r);
			`CHK(r, s7)
		end
		// Random control words, including the read-only flag and sync modes
		for (int k = 0; k < 5; k++) begin
			cw = $random(seed) & 32'h01ff_000a;
			u_host.wr(ADDR_MAIN_CONTROL, {32'h0, cw}, 32);
			`CHK(sine_select, cw[BIT_SINE])
			`CHK(lock_sync_oe, ~(cw[BIT_AUTO_SYNC] | cw[BIT_HW_SYNC]))
			u_host.rd(ADDR_MAIN_CONTROL, 32, r);
			`CHK(r[31:0], exp_ctrl(cw))
		end
		// Frame cut after two data bytes leaves the register alone
		u_host.xfer({3'b000, ADDR_MAIN_CONTROL}, 64'h0010_0000, 32, 16, r);
		u_host.rd(ADDR_MAIN_CONTROL, 32, r);
		`CHK(r[31:0], exp_ctrl(cw))
		// Loss of lock in hardware sync mode
		u_host.wr(ADDR_MAIN_CONTROL, 64'h2, 32);
		`CHK(lock_sync_oe, 1'b0)
		@(negedge sys_clk) pll_locked <= 1'b0;
		repeat (3) @(negedge sys_clk);
		pll_locked <= 1'b1;
		u_host.rd(ADDR_MAIN_CONTROL, 32, r);
		`CHK(r[31:0], 32'h0100_0002)
		u_host.rd(ADDR_MAIN_CONTROL, 32, r);
		`CHK(r[31:0], 32'h0000_0002)
		adv_count = 0;
		@(negedge sys_clk) sync_drive <= 1'b1;
		repeat (3) @(negedge sys_clk);
		sync_drive <= 1'b0;
		repeat (3) @(negedge sys_clk);
		`CHK(adv_count, 1)
		u_host.wr(ADDR_MAIN_CONTROL, 64'h0, 32);
		`CHK({lock_sync_oe, lock_sync_out}, 2'b11)
		// Sweep setup: end word three whole steps above start
		sw = {4'h0, $random(seed), 12'h0} | 48'h0000_0000_0fff;
		dw = {16'h0, $random(seed)} | 48'h1;
		ew = sw + 3 * dw;
		delta_word = dw;
		ramp_rate_value = 16'h0003;
		s6 = {2'b00, 14'($random(seed)), sw};
		s7 = {s6[63:48], ew};
		u_host.wr(ADDR_PROFILE_SIX, s6, 64);
		u_host.wr(ADDR_PROFILE_SEVEN, s7, 64);
		// Single tone follows the selected slot; phase hold shows the bare offset
		u_host.wr(ADDR_MAIN_CONTROL, 64'h0004_0000, 32);
		repeat (3) @(negedge sys_clk);
		`CHK(tuning_word, sw)
		`CHK(phase_word, s6[61:48])
		profile_select_zero <= 1'b1;
		repeat (3) @(negedge sys_clk);
		`CHK(tuning_word, ew)
		// Dwell at the end word
		u_host.wr(ADDR_MAIN_CONTROL, 64'h0002_0000, 32);
		restart();
		wait_word(ew, 200);
		hold_word(ew, 30);
		// No dwell: back to start and stay there
		u_host.wr(ADDR_MAIN_CONTROL, 64'h0003_0000, 32);
		restart();
		wait_word(ew, 200);
		wait_word(sw, 20);
		hold_word(sw, 30);
		// Update strobe clears the frequency accumulator and the sweep resumes
		u_host.wr(ADDR_MAIN_CONTROL, 64'h0042_0000, 32);
		restart();
		wait_word(ew, 200);
		pulse_update();
		wait_word(sw, 20);
		wait_word(ew, 200);
		// Frequency hold overrides an enabled sweep
		u_host.wr(ADDR_MAIN_CONTROL, 64'h000a_0000, 32);
		restart();
		hold_word(sw, 20);
		// Strobes keep reloading a slow ramp counter, so the sweep stalls at its start word
		ramp_rate_value <= 16'h0020;
		u_host.wr(ADDR_MAIN_CONTROL, 64'h0082_0000, 32);
		restart();
		repeat (4) begin
			pulse_update();
			hold_word(sw, 12);
		end
		wait_word(ew, 400);
		// Update strobe clears the phase accumulator once
		u_host.wr(ADDR_MAIN_CONTROL, 64'h0020_0000, 32);
		repeat (5) @(negedge sys_clk);
		pulse_update();
		found = 1'b0;
		repeat (10) begin
			@(negedge sys_clk);
			found |= (phase_word === s6[61:48]);
		end
		`CHK(found, 1'b1)
		print_verdict();
	end
endmodule
